//--- rtl/clkmux_cfg.svh
// Offsets, field positions, reset values and timing counts of the block
`ifndef CLKMUX_CFG_SVH
`define CLKMUX_CFG_SVH
`define OFS_CTRL 8'h00
`define OFS_STAT 8'h04
`define OFS_SEL 8'h08
`define CTRL_FREEZE 0
`define CTRL_MUL_LSB 8
`define CTRL_DIV_LSB 16
`define MUL_RESET 8'h04
`define DIV_RESET 8'h01
`define SEL_RESET 18'h00000
`define LOCK_EDGES 4
`define VCO_PER_MIN 24'h000002
`define VCO_PER_MAX 24'h000040
`define NUM_GLOBAL_CLOCK_LINE 8
`define NUM_DED 4
`define NUM_DP 8
`endif

//--- rtl/clkmux_pkg.sv
// Types shared by the clock control block
`default_nettype none
`include "clkmux_cfg.svh"
package clkmux_pkg;
    typedef enum logic [1:0] {
        SRC_DED = 2'b00,
        SRC_DP = 2'b01,
        SRC_PLL = 2'b10,
        SRC_INT = 2'b11
    } src_type;
    typedef struct packed {
        logic [14:0] sync1;
        logic [14:0] sync2;
        logic prev_ref;
        logic [15:0] period_cnt;
        logic [15:0] period;
        logic per_valid;
        logic [3:0] lock_cnt;
        logic lock;
        logic in_range;
        logic [23:0] acc;
        logic pll_g0;
        logic pll_g1;
        logic frozen;
        logic [7:0] mul;
        logic [7:0] div;
        logic [15:0] sel;
        logic [1:0] ref_sel;
        logic [7:0] global_clock_line;
        logic [31:0] rdata;
    } state_type;
endpackage
`default_nettype wire

//--- rtl/clkmux_top.sv
// PLL control model and global clock line routing
`timescale 1ns/10ps
`default_nettype none
`include "clkmux_cfg.svh"

// Operation
// - Enable low: unlock, PLL outputs low
// - Reset high: unlock, PLL outputs low
// - Detector off: lock undefined, outputs keep running; the code holds lock low
// - Lock within 2 to 10 input cycles
// - Input times M over N out of range: unlock
// - Eight global lines, four source kinds
// - Every line reaches all device resources
// - Lines also carry high-fanout control signals
// - Dedicated inputs feed PLL or lines
// - Dedicated input to fixed line pairs only
// - Each dual-purpose pin drives one line
module clkmux_top import clkmux_pkg::*; #(
    parameter int LOCK_EDGES = `LOCK_EDGES
) (
    input wire logic I_REF_CLK,
    input wire logic I_NRST,
    input wire logic [3:0] I_DED_CLK,
    input wire logic [7:0] I_DUAL_PURPOSE_CLOCK_PINS,
    input wire logic [7:0] I_INT_SRC,
    input wire logic I_PLL_ENA,
    input wire logic I_PLL_ARESET,
    input wire logic I_PFD_ENA,
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    output logic [7:0] O_GLOBAL_CLOCK_LINE,
    output logic O_PLL_LOCK,
    output logic O_PLL_G0,
    output logic O_PLL_G1
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic vco_ok(input logic [15:0] per,
                                    input logic [7:0] m,
                                    input logic [7:0] n);
        logic [23:0] pn;
        logic [31:0] lo;
        logic [31:0] hi;
        pn = 24'(per * n);
        lo = m * `VCO_PER_MIN;
        hi = m * `VCO_PER_MAX;
        return (32'(pn) >= lo) && (32'(pn) <= hi);
    endfunction

    // Dedicated input allowed on a line: 0,2->0 1,3->1 4,6->2 5,7->3
    function automatic logic [1:0] ded_of(input logic [2:0] line);
        return {line[2], line[0]};
    endfunction

    // Dual-purpose pin wired to each line
    function automatic logic [2:0] dp_of(input logic [2:0] line);
        case (line)
            3'h0: return 3'h2;
            3'h1: return 3'h7;
            3'h2: return 3'h1;
            3'h3: return 3'h0;
            3'h4: return 3'h3;
            3'h5: return 3'h6;
            3'h6: return 3'h4;
            default: return 3'h5;
        endcase
    endfunction

    state_type q;
    state_type d;

    logic [3:0] ded_s;
    logic [7:0] dp_s;
    logic ena_s;
    logic arst_s;
    logic pfd_s;
    logic ref_s;
    logic ref_edge;
    logic run;
    logic [23:0] thresh;
    logic [23:0] acc_sum;
    logic in_rng;

    assign ded_s = q.sync2[3:0];
    assign dp_s = q.sync2[11:4];
    assign ena_s = q.sync2[12];
    assign arst_s = q.sync2[13];
    assign pfd_s = q.sync2[14];
    assign run = ena_s && !arst_s;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.sync1 = {I_PFD_ENA, I_PLL_ARESET, I_PLL_ENA,
                   I_DUAL_PURPOSE_CLOCK_PINS, I_DED_CLK};
        d.sync2 = q.sync1;
        ref_s = ded_s[q.ref_sel];
        ref_edge = ref_s && !q.prev_ref;
        d.prev_ref = ref_s;
        thresh = 24'(q.period * q.div);
        acc_sum = q.acc + {15'h0000, q.mul, 1'b0};
        in_rng = vco_ok(q.period_cnt, q.mul, q.div);

        // Register writes; selection freezes for good
        if (I_WR && I_ADDR == `OFS_CTRL) begin
            d.mul = I_WDATA[`CTRL_MUL_LSB +: 8];
            d.div = I_WDATA[`CTRL_DIV_LSB +: 8];
            if (I_WDATA[`CTRL_FREEZE]) begin
                d.frozen = 1'b1;
            end
        end
        if (I_WR && I_ADDR == `OFS_SEL && !q.frozen) begin
            d.sel = I_WDATA[15:0];
            d.ref_sel = I_WDATA[17:16];
        end
        d.rdata = 32'h00000000;
        if (I_RD) begin
            case (I_ADDR)
                `OFS_CTRL: d.rdata = {8'h00, q.div, q.mul,
                                      7'h00, q.frozen};
                `OFS_STAT: d.rdata = {q.period, 13'h0000,
                                      q.per_valid, q.in_range, q.lock};
                `OFS_SEL: d.rdata = {14'h0000, q.ref_sel, q.sel};
                default: d.rdata = 32'h00000000;
            endcase
        end

        // Input period measure and range check
        if (q.period_cnt != 16'hFFFF) begin
            d.period_cnt = q.period_cnt + 16'h0001;
        end
        if (!run) begin
            d.lock = 1'b0;
            d.lock_cnt = 4'h0;
            d.acc = 24'h000000;
            d.pll_g0 = 1'b0;
            d.pll_g1 = 1'b0;
            d.per_valid = 1'b0;
            d.in_range = 1'b0;
            if (ref_edge) begin
                d.period_cnt = 16'h0001;
            end
        end else begin
            if (ref_edge && pfd_s) begin
                d.period_cnt = 16'h0001;
                d.period = q.period_cnt;
                d.per_valid = 1'b1;
                d.in_range = in_rng;
                if (!in_rng || !q.per_valid) begin
                    d.lock = 1'b0;
                    d.lock_cnt = 4'h0;
                end else if (q.lock_cnt == 4'(LOCK_EDGES - 1)) begin
                    d.lock = 1'b1;
                end else if (!q.lock) begin
                    d.lock_cnt = q.lock_cnt + 4'h1;
                end
            end
            if (!pfd_s) begin
                d.lock = 1'b0;
                d.lock_cnt = 4'h0;
            end
            // G0 runs at input times mul over div, G1 at half that, last set rate
            if (q.per_valid && thresh != 24'h000000) begin
                if (acc_sum >= thresh) begin
                    d.acc = acc_sum - thresh;
                    d.pll_g0 = !q.pll_g0;
                    if (!q.pll_g0) begin
                        d.pll_g1 = !q.pll_g1;
                    end
                end else begin
                    d.acc = acc_sum;
                end
            end
        end

        // Global line routing, one source each
        for (int l = 0; l < `NUM_GLOBAL_CLOCK_LINE; l++) begin
            case (src_type'(q.sel[2*l +: 2]))
                SRC_DED: d.global_clock_line[l] = ded_s[ded_of(3'(l))];
                SRC_DP: d.global_clock_line[l] = dp_s[dp_of(3'(l))];
                SRC_PLL: d.global_clock_line[l] = (l == 1 || l == 2 || l == 5 ||
                                      l == 6) ? q.pll_g0 : q.pll_g1;
                SRC_INT: d.global_clock_line[l] = I_INT_SRC[l];
                default: d.global_clock_line[l] = 1'b0;
            endcase
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            q <= '0;
            q.mul <= `MUL_RESET;
            q.div <= `DIV_RESET;
            {q.ref_sel, q.sel} <= `SEL_RESET;
        end else begin
            q <= d;
        end
    end

    // Lines fan out to all logic, memory and I/O
    assign O_GLOBAL_CLOCK_LINE = q.global_clock_line;
    assign O_PLL_LOCK = q.lock;
    assign O_PLL_G0 = q.pll_g0;
    assign O_PLL_G1 = q.pll_g1;
    assign O_RDATA = q.rdata;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_NRST);

    sequence pll_off_s;
        !q.lock && !q.pll_g0 && !q.pll_g1;
    endsequence

    ena_low_a: assert property (!ena_s |=> pll_off_s)
        else $error("PLL not stopped while disabled");
    arst_high_a: assert property (arst_s |=> pll_off_s)
        else $error("PLL not stopped in reset");
    pfd_hold_a: assert property (!pfd_s |=> !q.lock &&
                                 $stable(q.period))
        else $error("Detector off changed period or lock");
    lock_time_a: assert property ($rose(q.lock) |->
                                  $past(q.lock_cnt) ==
                                  4'(LOCK_EDGES - 1))
        else $error("Lock asserted at wrong edge count");
    lock_range_a: assert property (q.lock |-> q.in_range
                                   && q.per_valid)
        else $error("Locked while out of range");
    ded_route_a: assert property (q.sel[1:0] == 2'b00 |=>
                                  q.global_clock_line[0] == $past(ded_s[0]))
        else $error("Line 0 not from dedicated input 0");
    dp_route_a: assert property (q.sel[3:2] == 2'b01 |=>
                                 q.global_clock_line[1] == $past(dp_s[7]))
        else $error("Line 1 not from dual-purpose pin 7");
    sel_frozen_a: assert property (q.frozen |=>
                                   $stable(q.sel) && q.frozen)
        else $error("Selection changed after freeze");
    int_route_a: assert property (q.sel[15:14] == 2'b11 |=>
                                  q.global_clock_line[7] == $past(I_INT_SRC[7]))
        else $error("Line 7 not from internal source");

    // ------------------------------------------------------------
    // Range, count and routing checks
    // ------------------------------------------------------------
    sequence range_miss_s;
        run && pfd_s && ref_edge && !in_rng;
    endsequence

    sequence unlocked_s;
        !q.lock && !q.in_range && q.lock_cnt == 4'h0;
    endsequence

    range_drop_a: assert property (range_miss_s |=> unlocked_s)
        else $error("Lock kept with input out of range");
    ena_pin_a: assert property (!I_PLL_ENA |-> ##3 pll_off_s)
        else $error("PLL not stopped three cycles after disable");
    arst_pin_a: assert property (I_PLL_ARESET |-> ##3 pll_off_s)
        else $error("PLL not stopped three cycles after reset");
    lock_step_a: assert property (run && pfd_s && ref_edge &&
                                  in_rng && q.per_valid && !q.lock &&
                                  q.lock_cnt != 4'(LOCK_EDGES - 1)
                                  |=> q.lock_cnt == $past(q.lock_cnt) + 4'h1)
        else $error("Lock count did not advance");
    lock_max_a: assert property (q.lock_cnt <= 4'(LOCK_EDGES - 1))
        else $error("Lock count beyond its limit");
    pfd_runs_a: assert property (run && !pfd_s && q.per_valid &&
                                 thresh != 24'h000000 && acc_sum >= thresh
                                 |=> q.pll_g0 != $past(q.pll_g0))
        else $error("Output stopped while detector off");
    pll_g0_route_a: assert property (q.sel[3:2] == 2'b10 |=>
                                     q.global_clock_line[1] == $past(q.pll_g0))
        else $error("Line 1 not from PLL output 0");
    pll_g1_route_a: assert property (q.sel[1:0] == 2'b10 |=>
                                     q.global_clock_line[0] == $past(q.pll_g1))
        else $error("Line 0 not from PLL output 1");
    ded_pair_a: assert property (q.sel[5:4] == 2'b00 |=>
                                 q.global_clock_line[2] == $past(ded_s[0]))
        else $error("Line 2 not from dedicated input 0");
    ded_upper_a: assert property (q.sel[15:14] == 2'b00 |=>
                                  q.global_clock_line[7] == $past(ded_s[3]))
        else $error("Line 7 not from dedicated input 3");
    dp_pin6_a: assert property (q.sel[11:10] == 2'b01 |=>
                                q.global_clock_line[5] == $past(dp_s[6]))
        else $error("Line 5 not from dual-purpose pin 6");
    ref_pick_a: assert property (q.ref_sel == 2'h1 |=>
                                 q.prev_ref == $past(ded_s[1]))
        else $error("PLL reference not from chosen input");
    int_line0_a: assert property (q.sel[1:0] == 2'b11 |=>
                                  q.global_clock_line[0] == $past(I_INT_SRC[0]))
        else $error("Line 0 not from internal source");
    rd_idle_a: assert property (!I_RD |=> q.rdata == 32'h00000000)
        else $error("Read data outside its cycle");

endmodule
`default_nettype wire

//--- tb/clk_source_model.sv
// Board clock source that drives the dedicated clock pins
`timescale 1ns/10ps
`default_nettype none
module clk_source_model (
    input wire logic i_clk,
    input wire logic i_run,
    input wire logic [7:0] i_half,
    input wire logic [3:0] i_pat,
    output logic [3:0] o_ded
);
    logic [7:0] cnt_reg;
    logic ph_reg;
    // Free-running square wave while enabled, static pattern otherwise
    always @(posedge i_clk) begin
        if (!i_run || cnt_reg >= i_half - 8'h01) begin
            cnt_reg <= 8'h00;
            ph_reg <= i_run ? ~ph_reg : 1'b0;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
    assign o_ded = i_run ? {4{ph_reg}} : i_pat;
endmodule
`default_nettype wire

//--- tb/clkmux_top_bench.sv
// Self-checking bench for the clock control block
`timescale 1ns/10ps
`default_nettype none
module clkmux_top_bench;
    localparam logic [2:0] DPM [8] = '{3'h2, 3'h7, 3'h1, 3'h0,
                                       3'h3, 3'h6, 3'h4, 3'h5};
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic run = 1'b0;
    logic ena = 1'b0;
    logic ares = 1'b0;
    logic pfd = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] half = 8'h08;
    logic [3:0] pat = 4'h0;
    logic [3:0] ded;
    logic [7:0] dp = 8'h00;
    logic [7:0] isrc = 8'h00;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic [31:0] rdata;
    logic [31:0] rv;
    logic [7:0] gl;
    logic lock;
    logic g0;
    logic g1;
    int num_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n0;
    int n1;
    always #2 clk = ~clk;
    clk_source_model clk_source_model_inst (.i_clk(clk), .i_run(run),
        .i_half(half), .i_pat(pat), .o_ded(ded));
    clkmux_top #(.LOCK_EDGES(4)) clkmux_top_inst (.I_REF_CLK(clk),
        .I_NRST(nrst), .I_DED_CLK(ded), .I_DUAL_PURPOSE_CLOCK_PINS(dp),
        .I_INT_SRC(isrc), .I_PLL_ENA(ena), .I_PLL_ARESET(ares),
        .I_PFD_ENA(pfd), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
        .I_RD(rd), .O_RDATA(rdata), .O_GLOBAL_CLOCK_LINE(gl),
        .O_PLL_LOCK(lock), .O_PLL_G0(g0), .O_PLL_G1(g1));
    // ------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wait_lock(input logic v, input string nm);
        int n;
        n = 0;
        while (lock !== v && n < 400) begin
            @(posedge clk) #1;
            n++;
        end
        chk(nm, {31'h0, lock}, {31'h0, v});
    endtask
    // Drives distinct patterns on dedicated, dual-purpose and internal sources, checks each line
    task automatic route(input logic [15:0] sel, input string nm);
        logic [7:0] e;
        wr_reg(8'h08, {16'h0000, sel});
        for (int k = 0; k < 8; k++) begin
            @(posedge clk);
            pat <= 4'(k * 3);
            dp <= 8'h01 << k;
            isrc <= 8'hA5 >> k;
            repeat (4) @(posedge clk);
            #1;
            for (int l = 0; l < 8; l++) begin
                case (sel[2*l +: 2])
                    2'h0: e[l] = pat[{l[2], l[0]}];
                    2'h1: e[l] = dp[DPM[l]];
                    2'h2: e[l] = 1'b0;
                    default: e[l] = isrc[l];
                endcase
            end
            chk(nm, {24'h0, gl}, {24'h0, e});
        end
        $display("test done: %s", nm);
    endtask
    // Counts output toggles over 64 cycles; lines 1,2,5,6 carry G0
    task automatic rate(output int c0, output int c1);
        logic q0;
        logic q1;
        c0 = 0;
        c1 = 0;
        @(posedge clk) #1;
        q0 = g0;
        q1 = g1;
        repeat (64) begin
            @(posedge clk) #1;
            chk("pll lines", {24'h0, gl},
                {24'h0, q1, q0, q0, q1, q1, q0, q0, q1});
            c0 += int'(g0 !== q0);
            c1 += int'(g1 !== q1);
            q0 = g0;
            q1 = g1;
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            conclude();
        end
    end
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (7) @(posedge clk);
        #1 chk("reset outs", {21'h0, gl, lock, g0, g1}, 32'h0);
        @(posedge clk);
        nrst <= 1'b1;
        rd_reg(8'h00, rv);
        chk("ctrl reset", rv, 32'h00010400);
        rd_reg(8'h08, rv);
        chk("sel reset", rv, 32'h0);
        rd_reg(8'h0C, rv);
        chk("unmapped", rv, 32'h0);
        route(16'h0000, "dedicated");
        route(16'h5555, "dual purpose");
        route(16'hFFFF, "internal");
        route(16'hAAAA, "pll disabled");
        route(16'hE4E4, "mixed");
        wr_reg(8'h08, 32'h0001AAAA);
        run <= 1'b1;
        ena <= 1'b1;
        wait_lock(1'b1, "first lock");
        rd_reg(8'h04, rv);
        chk("status locked", rv, 32'h00100007);
        // Reference of 16 cycles times 4 over 1: output period 4 cycles
        rate(n0, n1);
        chk("g0 rate", n0, 32'h00000020);
        chk("g1 rate", n1, 32'h00000010);
        @(posedge clk);
        pfd <= 1'b0;
        repeat (4) @(posedge clk);
        rate(n0, n1);
        chk("pfd off runs", n0, 32'h00000020);
        chk("pfd off g1", n1, 32'h00000010);
        @(posedge clk);
        pfd <= 1'b1;
        wait_lock(1'b1, "relock");
        wr_reg(8'h00, 32'h00FF0400);
        wait_lock(1'b0, "out of range");
        wr_reg(8'h00, 32'h00010400);
        wait_lock(1'b1, "in range");
        @(posedge clk);
        half <= 8'h02;
        wait_lock(1'b0, "fast input");
        @(posedge clk);
        half <= 8'h08;
        wait_lock(1'b1, "input restored");
        @(posedge clk);
        ares <= 1'b1;
        wait_lock(1'b0, "areset unlock");
        repeat (5) @(posedge clk);
        #1 chk("areset outs", {22'h0, gl, g0, g1}, 32'h0);
        @(posedge clk);
        ares <= 1'b0;
        wait_lock(1'b1, "areset relock");
        @(posedge clk);
        ena <= 1'b0;
        wait_lock(1'b0, "disable unlock");
        repeat (5) @(posedge clk);
        #1 chk("disable outs", {22'h0, gl, g0, g1}, 32'h0);
        rd_reg(8'h04, rv);
        chk("status off", rv, 32'h00100000);
        $display("test done: pll control");
        wr_reg(8'h00, 32'h00010401);
        wr_reg(8'h08, 32'h0000FFFF);
        rd_reg(8'h08, rv);
        chk("frozen sel", rv, 32'h0001AAAA);
        rd_reg(8'h00, rv);
        chk("freeze bit", rv, 32'h00010401);
        $display("test done: freeze");
        conclude();
    end
endmodule
`default_nettype wire
